// [inc/lfw_pkg.sv]
// Holds the register map, field positions, reset values and timing counts of the LF wake receiver.
// Assumes a 40 MHz reference clock and an 8-bit register port with one-cycle read latency.
//
// Function
// RULE1 - mode field 01 selects carrier detect
// RULE2 - mode field 10 selects Manchester data
// RULE3 - bit 5 picks 88 or 176 us
// RULE4 - bit 4 picks 200 or 2120 us window
// RULE5 - Manchester window fixed at two oscillator clocks
// RULE6 - bits 3..0 set the sample interval
// RULE7 - enabled wake interrupt on carrier or byte
// RULE8 - off time is one or two periods
// RULE9 - software configures before setting the enable
// RULE10 - wake code length is 8 or 16
// RULE11 - software starts at low sensitivity
// RULE12 - select bit returns data or gain level
// RULE13 - coding error flag while waiting off
// RULE14 - data ready flag on stored byte
// RULE15 - software acknowledges flags at initialisation
// RULE16 - carrier flag set, cleared by bit 4
// RULE17 - bits 3 and 2 flag code B, A
// RULE18 - done bit is 1 after reception ends
// RULE19 - only optional data bytes reach software
// RULE20 - software loads wake codes before Manchester mode
// RULE21 - wake code registers plain storage otherwise
// RULE22 - ignore bit masks detector during sampling
// RULE23 - data ready only after accepted datagram byte
// RULE24 - flags sticky; new window each interval (done clears on a bit strobe or disable)
package lfw_pkg;

   // -----------------------------------------------------------------
   // Register offsets.
   // -----------------------------------------------------------------
   localparam logic [2:0] ADDR_MODE_TIMING = 3'h0;  // Mode and timing control.
   localparam logic [2:0] ADDR_CS_ZERO     = 3'h1;  // Control/status zero.
   localparam logic [2:0] ADDR_CS_ONE      = 3'h2;  // Control/status one.
   localparam logic [2:0] ADDR_RX_DATA     = 3'h3;  // Received data or gain level.
   localparam logic [2:0] ADDR_CODE_A0     = 3'h4;  // Wake code A, low byte.
   localparam logic [2:0] ADDR_CODE_A1     = 3'h5;  // Wake code A, high byte.
   localparam logic [2:0] ADDR_CODE_B0     = 3'h6;  // Wake code B, low byte.
   localparam logic [2:0] ADDR_CODE_B1     = 3'h7;  // Wake code B, high byte.

   // -----------------------------------------------------------------
   // Field positions.
   // -----------------------------------------------------------------
   localparam int MODE_HI      = 7;  // Receive mode select, upper bit.
   localparam int MODE_LO      = 6;  // Receive mode select, lower bit.
   localparam int CARR_MIN_BIT = 5;  // Carrier minimum duration select.
   localparam int WIN_LEN_BIT  = 4;  // Sample window length.
   localparam int RATE_HI      = 3;  // Sample rate select, upper bit.
   localparam int DET_OUT_BIT  = 7;  // Detector output status.
   localparam int IRQ_EN_BIT   = 6;  // Receiver interrupt enable.
   localparam int CODE_ERR_BIT = 5;  // Coding error, off status.
   localparam int OFF_TIME_BIT = 4;  // Off time select.
   localparam int ENABLE_BIT   = 3;  // Receiver enable.
   localparam int CODE_LEN_BIT = 2;  // Wake code length select.
   localparam int SENS_BIT     = 1;  // Sensitivity select.
   localparam int GAIN_SEL_BIT = 0;  // Gain level readout select.
   localparam int RDY_BIT      = 7;  // Received byte ready flag.
   localparam int RX_ACK_BIT   = 6;  // Receive flags acknowledge.
   localparam int CARR_BIT     = 5;  // Carrier seen flag.
   localparam int CARR_ACK_BIT = 4;  // Carrier flag acknowledge.
   localparam int MATCH_B_BIT  = 3;  // Wake code B match.
   localparam int MATCH_A_BIT  = 2;  // Wake code A match.
   localparam int DONE_BIT     = 1;  // Manchester receive done.
   localparam int IGNORE_BIT   = 0;  // Detector ignore.

   // -----------------------------------------------------------------
   // Mode encodings and reset values.
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_CARRIER    = 2'h1;  // Carrier detect.
   localparam logic [1:0] MODE_MANCHESTER = 2'h2;  // Manchester data.
   localparam logic [7:0] RESET_BYTE      = 8'h00; // Reset of every register.

   // -----------------------------------------------------------------
   // Timing.
   // -----------------------------------------------------------------
   localparam int CLK_MHZ        = 40;    // Reference clock rate.
   localparam int CARR_SHORT_NS  = 88000; // Short carrier minimum.
   localparam int CARR_LONG_NS   = 176000;
   localparam int WIN_SHORT_NS   = 200000;
   localparam int WIN_LONG_NS    = 2120000;
   localparam int LFO_PERIOD_NS  = 1000000; // Slow oscillator period.
   localparam int LFO_WIN_CLOCKS = 2;       // Manchester window in oscillator clocks.
   localparam int RATE_BASE_MS   = 1;       // Interval for rate code 0.
   // Least times round up, so carrier counts use ceiling.
   localparam int CARR_SHORT_CYC = (CARR_SHORT_NS * CLK_MHZ + 999) / 1000;
   localparam int CARR_LONG_CYC  = (CARR_LONG_NS * CLK_MHZ + 999) / 1000;
   localparam int WIN_SHORT_CYC  = WIN_SHORT_NS * CLK_MHZ / 1000;
   localparam int WIN_LONG_CYC   = WIN_LONG_NS * CLK_MHZ / 1000;
   localparam int WIN_MAN_CYC    = LFO_WIN_CLOCKS * LFO_PERIOD_NS * CLK_MHZ / 1000;
   localparam int MS_CYC         = 1000000 * CLK_MHZ / 1000;

endpackage : lfw_pkg

// [rtl/lfw_receiver.sv]
// Holds the control, timing and flag logic of the LF wake receiver.
// Assumes an analog detector supplying carrier, data bit and strobe pins, plus gain level.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module lfw_receiver
#(
   parameter int MS_CYCLES = lfw_pkg::MS_CYC  // Clock cycles per millisecond.
)
(
   // Clock and reset.
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset,
   // Register port.
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // Detector pins.
   input  wire logic       i_det_carrier,
   input  wire logic       i_det_bit,
   input  wire logic       i_det_bit_strobe,
   input  wire logic       i_det_code_error,
   input  wire logic [7:0] i_gain_level,
   // Detector control and wake.
   output logic            o_det_power,
   output logic            o_low_sensitivity,
   output logic            o_wake_irq
);

   // -----------------------------------------------------------------
   // Pin synchronisers: three stages, change counts when 2 and 3 agree.
   // -----------------------------------------------------------------
   logic [3:0] sync1;       // First stage, read only by stage two.
   logic [3:0] sync2;       // Second stage.
   logic [3:0] sync3;       // Third stage.
   logic [3:0] pin_q;       // Filtered pin levels.
   logic [3:0] next_pin_q;  // Next filtered levels.
   logic [3:0] pin_prev;    // Previous filtered levels for edge finding.

   // Accepts a change only when the last two stages agree.
   always_comb
   begin
      next_pin_q = pin_q;
      for (int k = 0; k < 4; k++)
      begin
         if (sync2[k] == sync3[k])
         begin
            next_pin_q[k] = sync3[k];
         end
      end
   end

   // Registers the synchroniser chain.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         sync1    <= 4'h0;
         sync2    <= 4'h0;
         sync3    <= 4'h0;
         pin_q    <= 4'h0;
         pin_prev <= 4'h0;
      end
      else
      begin
         sync1    <= {i_det_code_error, i_det_bit_strobe, i_det_bit, i_det_carrier};
         sync2    <= sync1;
         sync3    <= sync2;
         pin_q    <= next_pin_q;
         pin_prev <= pin_q;
      end
   end

   // -----------------------------------------------------------------
   // Registers and sequencer state.
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,  // Disabled.
      ST_SAMPLE = 2'b01,  // Sample window open.
      ST_OFF    = 2'b10   // Waiting between windows.
   } lfw_state_t;

   lfw_state_t  state, next_state;          // Sequencer state.
   logic [7:0]  ctrl, next_ctrl;            // Mode and timing control.
   logic [7:0]  cs0, next_cs0;              // Writable bits of status zero.
   logic [7:0]  codes [4];                  // Wake code bytes A0, A1, B0, B1.
   logic [7:0]  next_codes [4];             // Next wake code bytes.
   logic [7:0]  rx_data, next_rx_data;      // Received data byte.
   logic [15:0] shift, next_shift;          // Incoming bit shifter.
   logic [4:0]  nbits, next_nbits;          // Bits collected.
   logic        accepted, next_accepted;    // Wake code matched.
   logic        rdy, next_rdy;              // Byte ready flag.
   logic        carr, next_carr;            // Carrier seen flag.
   logic        mat_a, next_mat_a;          // Code A match flag.
   logic        mat_b, next_mat_b;          // Code B match flag.
   logic        done, next_done;            // Manchester reception over.
   logic        cerr, next_cerr;            // Coding error, waiting off.
   logic        ign, next_ign;              // Detector ignore.
   logic [23:0] win_cnt, next_win_cnt;      // Window timer.
   logic [31:0] per_cnt, next_per_cnt;      // Interval timer.
   logic [1:0]  off_cnt, next_off_cnt;      // Skipped intervals.
   logic [23:0] carr_cnt, next_carr_cnt;    // Carrier duration counter.
   logic [7:0]  next_rdata;                 // Next read data.
   logic        next_irq;                   // Next wake interrupt.

   logic        man_mode;    // Manchester mode active.
   logic        car_mode;    // Carrier mode active.
   logic        det_c;       // Detector carrier, masked by ignore.
   logic        det_bit;     // Detector data bit, masked by ignore.
   logic        strobe;      // One-cycle bit strobe.
   logic [23:0] win_len;     // Window length in cycles.
   logic [23:0] carr_len;    // Carrier minimum in cycles.
   logic [31:0] per_len;     // Interval in cycles.

   // Interval for a rate code: base shifted by the code.
   function automatic logic [31:0] rate_cycles(input logic [3:0] code);
      rate_cycles = 32'(MS_CYCLES * lfw_pkg::RATE_BASE_MS) << code;
   endfunction : rate_cycles

   // Next-state logic for registers, flags and sequencer.
   always_comb
   begin
      man_mode = ctrl[lfw_pkg::MODE_HI:lfw_pkg::MODE_LO] == lfw_pkg::MODE_MANCHESTER; // RULE2
      car_mode = ctrl[lfw_pkg::MODE_HI:lfw_pkg::MODE_LO] == lfw_pkg::MODE_CARRIER;    // RULE1
      // The detector reads low in the window while ignore is set.
      det_c   = pin_q[0] & ~ign;                                  // RULE22
      det_bit = pin_q[1] & ~ign;                                  // RULE22
      strobe  = pin_q[2] & ~pin_prev[2] & ~ign & (state == ST_SAMPLE);
      // Window length depends on mode and length bit.
      if (man_mode)
      begin
         win_len = 24'(lfw_pkg::WIN_MAN_CYC);                     // RULE5
      end
      else
      begin
         win_len = ctrl[lfw_pkg::WIN_LEN_BIT] ? 24'(lfw_pkg::WIN_LONG_CYC)
                                              : 24'(lfw_pkg::WIN_SHORT_CYC); // RULE4
      end
      carr_len = ctrl[lfw_pkg::CARR_MIN_BIT] ? 24'(lfw_pkg::CARR_LONG_CYC)
                                             : 24'(lfw_pkg::CARR_SHORT_CYC); // RULE3
      per_len  = rate_cycles(ctrl[lfw_pkg::RATE_HI:0]);           // RULE6

      next_ctrl     = ctrl;
      next_cs0      = cs0;
      next_codes    = codes;
      next_rx_data  = rx_data;
      next_shift    = shift;
      next_nbits    = nbits;
      next_accepted = accepted;
      next_rdy      = rdy;
      next_carr     = carr;
      next_mat_a    = mat_a;
      next_mat_b    = mat_b;
      next_done     = done;
      next_cerr     = cerr;
      next_ign      = ign;
      next_state    = state;
      next_win_cnt  = win_cnt;
      next_off_cnt  = off_cnt;
      next_carr_cnt = 24'h0;
      next_per_cnt  = (per_cnt + 32'h1 >= per_len) ? 32'h0 : per_cnt + 32'h1;

      // Software writes; acknowledges come first so events win.
      if (i_wr)
      begin
         unique case (i_addr)
            lfw_pkg::ADDR_MODE_TIMING: next_ctrl = i_wdata;
            lfw_pkg::ADDR_CS_ZERO:     next_cs0  = i_wdata & 8'h5f;
            lfw_pkg::ADDR_CS_ONE:
            begin
               next_ign = i_wdata[lfw_pkg::IGNORE_BIT];
               if (i_wdata[lfw_pkg::RX_ACK_BIT])
               begin
                  next_rdy   = 1'b0;
                  next_mat_a = 1'b0;
                  next_mat_b = 1'b0;
                  next_done  = 1'b0;
               end
               if (i_wdata[lfw_pkg::CARR_ACK_BIT])
               begin
                  next_carr = 1'b0;                               // RULE16
               end
            end
            lfw_pkg::ADDR_RX_DATA:     next_ctrl = ctrl;
            default:                   next_codes[i_addr[1:0]] = i_wdata; // RULE21
         endcase
      end

      // Sampling sequencer.
      if (!cs0[lfw_pkg::ENABLE_BIT])                              // RULE9
      begin
         next_state    = ST_IDLE;
         next_per_cnt  = 32'h0;
         next_done     = 1'b0;
         next_cerr     = 1'b0;
         next_accepted = 1'b0;
      end
      else
      begin
         unique case (state)
            ST_IDLE:
            begin
               next_state   = ST_SAMPLE;
               next_win_cnt = 24'h0;
               next_per_cnt = 32'h0;
               next_nbits   = 5'h0;
            end
            ST_SAMPLE:
            begin
               next_win_cnt = win_cnt + 24'h1;
               if (car_mode && det_c)
               begin
                  next_carr_cnt = carr_cnt + 24'h1;
                  if (carr_cnt + 24'h1 >= carr_len)
                  begin
                     next_carr = 1'b1;                            // RULE16
                  end
               end
               if (man_mode && strobe)
               begin
                  next_shift = {shift[14:0], det_bit};
                  next_nbits = nbits + 5'h1;
                  next_done  = 1'b0;
                  if (pin_q[3])
                  begin
                     next_cerr     = 1'b1;                        // RULE13
                     next_done     = accepted;                    // RULE18
                     next_accepted = 1'b0;
                  end
                  else if (!accepted && ((!cs0[lfw_pkg::CODE_LEN_BIT] && nbits == 5'h7)
                          || nbits == 5'hf))                      // RULE10
                  begin
                     // Sync and identifier never reach the data register.
                     if (code_hit(next_shift, codes[0], codes[1]))
                     begin
                        next_mat_a    = 1'b1;                     // RULE17
                        next_accepted = 1'b1;
                        next_nbits    = 5'h0;
                     end
                     else if (code_hit(next_shift, codes[2], codes[3]))
                     begin
                        next_mat_b    = 1'b1;                     // RULE17
                        next_accepted = 1'b1;
                        next_nbits    = 5'h0;
                     end
                     else
                     begin
                        next_nbits = nbits;
                     end
                  end
                  else if (accepted && nbits == 5'h7)
                  begin
                     next_rx_data = next_shift[7:0];              // RULE19
                     next_rdy     = 1'b1;                         // RULE14 RULE23
                     next_nbits   = 5'h0;
                  end
               end
               // Stay open while a datagram is arriving.
               if (win_cnt + 24'h1 >= win_len && !(accepted && !next_cerr))
               begin
                  next_state   = ST_OFF;
                  next_off_cnt = cs0[lfw_pkg::OFF_TIME_BIT] ? 2'h2 : 2'h1; // RULE8
               end
            end
            ST_OFF:
            begin
               if (per_cnt + 32'h1 >= per_len)
               begin
                  next_off_cnt = off_cnt - 2'h1;
                  if (off_cnt == 2'h1)
                  begin
                     next_state   = ST_SAMPLE;                    // RULE24
                     next_win_cnt = 24'h0;
                     next_nbits   = 5'h0;
                     next_cerr    = 1'b0;
                  end
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end

      // Wake interrupt on carrier or byte.
      next_irq = cs0[lfw_pkg::IRQ_EN_BIT] &
                 ((car_mode & next_carr) | (man_mode & next_rdy)); // RULE7

      // Read data.
      next_rdata = 8'h00;
      if (i_rd)
      begin
         unique case (i_addr)
            lfw_pkg::ADDR_MODE_TIMING: next_rdata = ctrl;
            lfw_pkg::ADDR_CS_ZERO:
               next_rdata = cs0 | {pin_q[0], 1'b0, cerr, 5'h00}; // RULE13
            lfw_pkg::ADDR_CS_ONE:
               next_rdata = {rdy, 1'b0, carr, 1'b0, mat_b, mat_a, done, ign};
            lfw_pkg::ADDR_RX_DATA:
               next_rdata = cs0[lfw_pkg::GAIN_SEL_BIT] ? i_gain_level : rx_data; // RULE12
            default:                   next_rdata = codes[i_addr[1:0]];
         endcase
      end
   end

   // Compares the shifter with a wake code; a short code looks at the newest byte only,
   // so older bits left in the upper half cannot spoil the match.
   function automatic logic code_hit(input logic [15:0] got, input logic [7:0] lo,
                                     input logic [7:0] hi);
      code_hit = cs0[lfw_pkg::CODE_LEN_BIT] ? (got == {hi, lo}) : (got[7:0] == lo);
   endfunction : code_hit

   // Registers all state.
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         state             <= ST_IDLE;
         ctrl              <= lfw_pkg::RESET_BYTE;
         cs0               <= lfw_pkg::RESET_BYTE;
         codes             <= '{default: lfw_pkg::RESET_BYTE};
         rx_data           <= lfw_pkg::RESET_BYTE;
         shift             <= 16'h0000;
         nbits             <= 5'h00;
         accepted          <= 1'b0;
         rdy               <= 1'b0;
         carr              <= 1'b0;
         mat_a             <= 1'b0;
         mat_b             <= 1'b0;
         done              <= 1'b0;
         cerr              <= 1'b0;
         ign               <= 1'b0;
         win_cnt           <= 24'h000000;
         per_cnt           <= 32'h00000000;
         off_cnt           <= 2'h0;
         carr_cnt          <= 24'h000000;
         o_rdata           <= 8'h00;
         o_wake_irq        <= 1'b0;
         o_det_power       <= 1'b0;
         o_low_sensitivity <= 1'b0;
      end
      else
      begin
         state             <= next_state;
         ctrl              <= next_ctrl;
         cs0               <= next_cs0;
         codes             <= next_codes;
         rx_data           <= next_rx_data;
         shift             <= next_shift;
         nbits             <= next_nbits;
         accepted          <= next_accepted;
         rdy               <= next_rdy;
         carr              <= next_carr;
         mat_a             <= next_mat_a;
         mat_b             <= next_mat_b;
         done              <= next_done;
         cerr              <= next_cerr;
         ign               <= next_ign;
         win_cnt           <= next_win_cnt;
         per_cnt           <= next_per_cnt;
         off_cnt           <= next_off_cnt;
         carr_cnt          <= next_carr_cnt;
         o_rdata           <= next_rdata;
         o_wake_irq        <= next_irq;
         o_det_power       <= next_state == ST_SAMPLE;
         o_low_sensitivity <= next_cs0[lfw_pkg::SENS_BIT];
      end
   end

   // -----------------------------------------------------------------
   // Checks.
   // -----------------------------------------------------------------
   flag_sticky_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE24
      rdy && !(i_wr && i_addr == lfw_pkg::ADDR_CS_ONE && i_wdata[6]) |=> rdy)
      else $error("Ready flag dropped without acknowledge.");
   carr_ack_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE16
      carr && state != ST_SAMPLE && i_wr && i_addr == lfw_pkg::ADDR_CS_ONE && i_wdata[4]
      |=> !carr)
      else $error("Carrier acknowledge did not clear flag.");
   irq_cause_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE7
      o_wake_irq |-> $past(cs0[6]))
      else $error("Interrupt raised while disabled.");
   disabled_idle_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE9
      !cs0[3] |=> state == ST_IDLE)
      else $error("Sampling while disabled.");
   man_window_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE5
      man_mode && state == ST_SAMPLE |-> win_len == 24'(lfw_pkg::WIN_MAN_CYC))
      else $error("Manchester window not fixed.");
   rdy_needs_acc_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE23
      $rose(rdy) |-> $past(accepted))
      else $error("Byte ready without accepted datagram.");
   gain_read_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE12
      i_rd && i_addr == lfw_pkg::ADDR_RX_DATA && cs0[0] |=> o_rdata == $past(i_gain_level))
      else $error("Gain readout wrong.");
   carr_mode_only_a : assert property (@(posedge i_ref_clk) disable iff (i_reset) // RULE1
      $rose(carr) |-> $past(car_mode))
      else $error("Carrier flag outside carrier mode.");

endmodule : lfw_receiver

// [tb/lfw_detector_model.sv]
// Holds a behavioural detector front end that faces the receiver's pin side.
// Assumes the bench commands the carrier, data bit and bit strobe; the code error pin stays low.
`timescale 1ns/100ps
module lfw_detector_model
#(
   parameter logic [7:0] GAIN = 8'h5c  // Fixed gain level reported to the receiver.
)
(
   // Clock and command.
   input  wire logic       i_ref_clk,
   input  wire logic       i_carrier_on,
   input  wire logic       i_bit_cmd,
   input  wire logic       i_strobe_cmd,
   // Detector pins.
   output logic            o_carrier,
   output logic            o_bit,
   output logic            o_strobe,
   output logic            o_code_error,
   output logic      [7:0] o_gain
);
   // Carrier, decoded bit and bit strobe follow the bench's commands one cycle later.
   always_ff @(posedge i_ref_clk)
   begin
      o_carrier <= i_carrier_on;
      o_bit     <= i_bit_cmd;
      o_strobe  <= i_strobe_cmd;
   end
   assign o_code_error = 1'b0;
   assign o_gain       = GAIN;
endmodule : lfw_detector_model

// [tb/lfw_receiver_bench.sv]
// Holds the self-checking bench of the LF wake receiver in carrier detect and Manchester modes.
// Assumes a 40 MHz clock and a shortened millisecond of 4 cycles.
`timescale 1ns/100ps
module lfw_receiver_bench;
   logic i_ref_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, carrier_on = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata, gain, rd_val;
   logic det_c, det_b, det_s, det_e, o_det_power, o_low_sensitivity, o_wake_irq;
   logic bit_cmd = 1'b0, strobe_cmd = 1'b0;
   int err_count = 0, num_checks = 0, cycles = 0;
   lfw_receiver #(.MS_CYCLES(4)) dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_det_carrier(det_c), .i_det_bit(det_b), .i_det_bit_strobe(det_s),
      .i_det_code_error(det_e), .i_gain_level(gain), .o_det_power(o_det_power),
      .o_low_sensitivity(o_low_sensitivity), .o_wake_irq(o_wake_irq));
   lfw_detector_model #(.GAIN(8'h5c)) far (.i_ref_clk(i_ref_clk), .i_carrier_on(carrier_on),
      .i_bit_cmd(bit_cmd), .i_strobe_cmd(strobe_cmd),
      .o_carrier(det_c), .o_bit(det_b), .o_strobe(det_s), .o_code_error(det_e), .o_gain(gain));
   initial forever #12.5 i_ref_clk = ~i_ref_clk;
   // A hang is cut short well beyond the longest carrier wait.
   always @(posedge i_ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         err_count = err_count + 1;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
   begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask : chk
   // One write cycle, then the strobe drops and one idle edge passes.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
   begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      @(posedge i_ref_clk);
   end
   endtask : wr
   // One read cycle; data is taken at the rising edge that closes the following cycle.
   task automatic rd(input logic [2:0] a);
   begin
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(posedge i_ref_clk);
      rd_val = o_rdata;
   end
   endtask : rd
   // Sends one byte, upper bit first, each bit settled before its strobe rises.
   task automatic send_byte(input logic [7:0] b);
   begin
      for (int k = 7; k >= 0; k--)
      begin
         bit_cmd <= b[k];
         repeat (4) @(posedge i_ref_clk);
         strobe_cmd <= 1'b1;
         repeat (6) @(posedge i_ref_clk);
         strobe_cmd <= 1'b0;
         repeat (4) @(posedge i_ref_clk);
      end
   end
   endtask : send_byte
   // Manchester mode: an 8-bit code A match, then one data byte reaches the data register.
   task automatic manchester_rx();
   begin
      wr(3'h1, 8'h00); wr(3'h0, 8'h84);
      wr(3'h1, 8'h08);
      repeat (4) @(posedge i_ref_clk);
      send_byte(8'ha4);
      rd(3'h2); chk(rd_val, 8'h04);
      send_byte(8'h3c);
      rd(3'h2); chk(rd_val, 8'h84);
      rd(3'h3); chk(rd_val, 8'h3c);
      rd(3'h0); chk(rd_val, 8'h84);
   end
   endtask : manchester_rx
   task automatic give_verdict();
   begin
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask : give_verdict
   // Wake code storage and gain readout behave as plain registers outside Manchester mode.
   task automatic storage_and_gain();
   begin
      for (int k = 4; k < 8; k++) wr(3'(k), 8'(8'ha0 + k));
      for (int k = 4; k < 8; k++) begin rd(3'(k)); chk(rd_val, 8'(8'ha0 + k)); end
      wr(3'h1, 8'h03);
      rd(3'h3); chk(rd_val, 8'h5c);
      chk({7'h00, o_low_sensitivity}, 8'h01);
   end
   endtask : storage_and_gain
   // Carrier qualifies, raises flag and wake, then acknowledge clears both.
   task automatic carrier_detect();
   int n;
   begin
      wr(3'h0, 8'h45); wr(3'h2, 8'h50); wr(3'h1, 8'h5a);
      rd(3'h0); chk(rd_val, 8'h45);
      n = 0;
      while (o_det_power !== 1'b1 && n < 300) begin @(posedge i_ref_clk); n++; end
      chk({7'h00, o_det_power}, 8'h01);
      carrier_on <= 1'b1;
      rd(3'h2); chk({7'h00, rd_val[5]}, 8'h00);
      repeat (3560) @(posedge i_ref_clk);
      rd(3'h2); chk({7'h00, rd_val[5]}, 8'h01);
      chk({7'h00, o_wake_irq}, 8'h01);
      carrier_on <= 1'b0;
      repeat (6) @(posedge i_ref_clk);
      wr(3'h2, 8'h10); rd(3'h2); chk(rd_val, 8'h00);
      chk({7'h00, o_wake_irq}, 8'h00);
   end
   endtask : carrier_detect
   initial
   begin
      repeat (4) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      @(posedge i_ref_clk);
      rd(3'h2); chk(rd_val, 8'h00);
      storage_and_gain();
      carrier_detect();
      manchester_rx();
      give_verdict();
   end
endmodule : lfw_receiver_bench
